// ==== pkg/esc_consts.vh ====
// constants for the error sense compensator
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH
// timing
`define ESC_CLK_MHZ 40
`define ESC_STARTUP_US 100
`define ESC_STARTUP_CYC (`ESC_STARTUP_US * `ESC_CLK_MHZ)
`define ESC_SLEW_UV_PER_US 156
`define ESC_DAC_LSB_UV 1000
`define ESC_SLEW_CYC ((`ESC_DAC_LSB_UV * `ESC_CLK_MHZ) / `ESC_SLEW_UV_PER_US)
// register byte offsets
`define ESC_A_CTRL 12'h000
`define ESC_A_STATUS 12'h004
`define ESC_A_PERIOD 12'h008
`define ESC_A_STIME 12'h00C
`define ESC_A_VNOM 12'h010
`define ESC_A_VMHI 12'h014
`define ESC_A_VMLO 12'h018
`define ESC_A_OPER 12'h01C
`define ESC_A_LIGHT 12'h020
`define ESC_A_NLLIM 12'h024
`define ESC_A_NLG03 12'h028
`define ESC_A_NLG4 12'h02C
`define ESC_A_REF 12'h030
`define ESC_A_COMP 12'h034
`define ESC_A_COEF_PAGE 4'h1
// fields
`define ESC_OP_SUPPRESS 2
`define ESC_OP_SEL_HI 2'b01
`define ESC_OP_SEL_LO 2'b10
`define ESC_ST_RUN 0
`define ESC_ST_SAT 1
`define ESC_ST_BANK 2
`define ESC_ST_CODE 16
// coefficient slots inside one bank
`define ESC_CI_AFE 0
`define ESC_CI_B0 1
`define ESC_CI_B1 2
`define ESC_CI_B2 3
`define ESC_CI_A1 4
`define ESC_CI_A2 5
`define ESC_CI_C0 6
`define ESC_CI_C1 7
`define ESC_CI_D1 8
`define ESC_NCOEF 9
`define ESC_NBANK 3
`define ESC_QSHIFT 12
// reset values
`define ESC_RST_PERIOD 16'h0028
`define ESC_RST_STIME 16'h0014
`define ESC_RST_COEF_UNITY 16'h1000
`define ESC_RST_NLLIM 24'h0000_00
`define ESC_RST_NLG03 32'h1010_1010
`define ESC_RST_NLG4 8'h10
`define ESC_REF_MAX 10'h3FF
`endif

// ==== hdl/esc_nlgain.v ====
// nonlinear gain stage: picks one of five gains by error region
`timescale 1ns/10ps
`default_nettype none
`include "esc_consts.vh"
module esc_nlgain (
  input wire [5:0] err_code,
  input wire [23:0] limits,
  input wire [39:0] gains,
  output wire [15:0] gained
);
  wire [3:0] above;
  reg [2:0] sel;
  wire [7:0] g;
  wire signed [14:0] prod;

  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_lim
      // signed compare, limits need not be symmetric
      assign above[n] = $signed(err_code) > $signed(limits[6*n+5:6*n]);
    end
  endgenerate

  // region index: gain n between limit n-1 and limit n
  always @* begin
    sel = {2'b00, above[0]} + {2'b00, above[1]} +
          {2'b00, above[2]} + {2'b00, above[3]};
  end

  assign g = gains[8*sel +: 8];
  // gains are unsigned with four fraction bits
  assign prod = $signed(err_code) * $signed({1'b0, g});
  assign gained = {prod[14], prod};
endmodule
`default_nettype wire

// ==== hdl/esc_top.v ====
// error sense compensator: bus slave, front end, slew and filter
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "esc_consts.vh"
// ********************************************************************
// ********************************************************************
module esc_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire external_reset_n,
  input wire [11:0] sense_positive_input,
  input wire [11:0] sense_negative_input,
  input wire soft_ramp_active,
  input wire [11:0] output_current,
  output wire [9:0] ref_dac,
  output wire [15:0] comp_out,
  output wire comp_valid,
  output wire fault_suppress
);
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  localparam integer SU_LAST_I = `ESC_STARTUP_CYC - 1;
  localparam integer SLEW_LAST_I = `ESC_SLEW_CYC - 1;
  localparam [11:0] STARTUP_LAST = SU_LAST_I[11:0];
  localparam [8:0] SLEW_LAST = SLEW_LAST_I[8:0];
  integer i;

  // ******************************************************************
  // input synchronisers
  // ******************************************************************
  reg [1:0] xr_q;
  reg [1:0] ramp_q;
  reg [11:0] sp1_q, sp2_q, sn1_q, sn2_q, io1_q, io2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xr_q <= 2'b00;
      ramp_q <= 2'b00;
      sp1_q <= 12'h000;
      sp2_q <= 12'h000;
      sn1_q <= 12'h000;
      sn2_q <= 12'h000;
      io1_q <= 12'h000;
      io2_q <= 12'h000;
    end else begin
      xr_q <= {xr_q[0], external_reset_n};
      ramp_q <= {ramp_q[0], soft_ramp_active};
      sp1_q <= sense_positive_input;
      sp2_q <= sp1_q;
      sn1_q <= sense_negative_input;
      sn2_q <= sn1_q;
      io1_q <= output_current;
      io2_q <= io1_q;
    end
  end

  // ******************************************************************
  // bus slave
  // ******************************************************************
  reg ap_wr_q, ap_rd_q, hreadyout_q, hresp_q;
  reg [11:0] ap_addr_q;
  reg [31:0] hrdata_q;
  reg [31:0] rd_d;
  wire take = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 12'h000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ap_wr_q <= take & hwrite;
      ap_rd_q <= take & ~hwrite;
      // reads take one wait state so a preceding write is visible
      hreadyout_q <= ~(take & ~hwrite);
      if (take) begin
        ap_addr_q <= haddr[11:0];
      end
      if (ap_rd_q) begin
        hrdata_q <= rd_d;
      end
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  reg en_q;
  reg [15:0] period_q, stime_q;
  reg [9:0] vnom_q, vmhi_q, vmlo_q;
  reg [2:0] oper_q;
  reg [11:0] light_q;
  reg [23:0] nllim_q;
  reg [39:0] nlg_q;
  reg [15:0] coef_q [0:26];
  wire [1:0] c_bank = ap_addr_q[7:6];
  wire [3:0] c_idx = ap_addr_q[5:2];
  wire c_hit = (ap_addr_q[11:8] == `ESC_A_COEF_PAGE) &&
               (c_bank < 2'd3) && (c_idx < 4'd9);
  wire [4:0] c_ptr = c_bank * 5'd9 + {1'b0, c_idx};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b1;
      period_q <= `ESC_RST_PERIOD;
      stime_q <= `ESC_RST_STIME;
      vnom_q <= 10'h000;
      vmhi_q <= 10'h000;
      vmlo_q <= 10'h000;
      oper_q <= 3'b000;
      light_q <= 12'h000;
      nllim_q <= `ESC_RST_NLLIM;
      nlg_q <= {`ESC_RST_NLG4, `ESC_RST_NLG03};
      for (i = 0; i < 27; i = i + 1) begin
        coef_q[i] <= (i % 9 == 1 || i % 9 == 6) ?
                     `ESC_RST_COEF_UNITY : 16'h0000;
      end
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        `ESC_A_CTRL: en_q <= hwdata[0];
        `ESC_A_PERIOD: period_q <= hwdata[15:0];
        `ESC_A_STIME: stime_q <= hwdata[15:0];
        `ESC_A_VNOM: vnom_q <= hwdata[9:0];
        `ESC_A_VMHI: vmhi_q <= hwdata[9:0];
        `ESC_A_VMLO: vmlo_q <= hwdata[9:0];
        `ESC_A_OPER: oper_q <= hwdata[2:0];
        `ESC_A_LIGHT: light_q <= hwdata[11:0];
        `ESC_A_NLLIM: nllim_q <= hwdata[23:0];
        `ESC_A_NLG03: nlg_q[31:0] <= hwdata;
        `ESC_A_NLG4: nlg_q[39:32] <= hwdata[7:0];
        default: begin
          if (c_hit) begin
            coef_q[c_ptr] <= hwdata[15:0];
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // loop state declarations
  // ******************************************************************
  reg [2:0] st_q;
  reg [11:0] su_cnt_q;
  reg [15:0] pc_q;
  reg [1:0] bank_q;
  reg [9:0] ref_q;
  reg [8:0] slew_cnt_q;
  reg s1_q, s2_q, comp_valid_q, fsup_q;
  reg signed [12:0] diff_q;
  reg [5:0] code_q;
  reg signed [15:0] x1_q, x2_q, y1_q, y2_q, z1_q, comp_q;
  wire running = (st_q == ST_RUN) & en_q;
  wire sat_hi = (code_q == 6'h1F);
  wire sat_lo = (code_q == 6'h20);

  always @* begin
    rd_d = 32'h0000_0000;
    case (ap_addr_q)
      `ESC_A_CTRL: rd_d[0] = en_q;
      `ESC_A_STATUS: begin
        rd_d[`ESC_ST_RUN] = running;
        rd_d[`ESC_ST_SAT] = sat_hi | sat_lo;
        rd_d[`ESC_ST_BANK+1:`ESC_ST_BANK] = bank_q;
        rd_d[`ESC_ST_CODE+5:`ESC_ST_CODE] = code_q;
      end
      `ESC_A_PERIOD: rd_d[15:0] = period_q;
      `ESC_A_STIME: rd_d[15:0] = stime_q;
      `ESC_A_VNOM: rd_d[9:0] = vnom_q;
      `ESC_A_VMHI: rd_d[9:0] = vmhi_q;
      `ESC_A_VMLO: rd_d[9:0] = vmlo_q;
      `ESC_A_OPER: rd_d[2:0] = oper_q;
      `ESC_A_LIGHT: rd_d[11:0] = light_q;
      `ESC_A_NLLIM: rd_d[23:0] = nllim_q;
      `ESC_A_NLG03: rd_d = nlg_q[31:0];
      `ESC_A_NLG4: rd_d[7:0] = nlg_q[39:32];
      `ESC_A_REF: rd_d[9:0] = ref_q;
      `ESC_A_COMP: rd_d[15:0] = comp_q;
      default: begin
        if (c_hit) begin
          rd_d[15:0] = coef_q[c_ptr];
        end
      end
    endcase
  end

  // ******************************************************************
  // reset and startup sequence
  // ******************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_HOLD;
      su_cnt_q <= 12'h000;
    end else if (!xr_q[1]) begin
      st_q <= ST_HOLD;
      su_cnt_q <= 12'h000;
    end else begin
      case (st_q)
        ST_HOLD: begin
          st_q <= ST_WAIT;
          su_cnt_q <= 12'h000;
        end
        ST_WAIT: begin
          su_cnt_q <= su_cnt_q + 12'h001;
          if (su_cnt_q == STARTUP_LAST) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_HOLD;
      endcase
    end
  end

  // ******************************************************************
  // bank, reference selection and slewing
  // ******************************************************************
  reg [9:0] tgt;
  always @* begin
    case (oper_q[1:0])
      `ESC_OP_SEL_HI: tgt = vmhi_q;
      `ESC_OP_SEL_LO: tgt = vmlo_q;
      default: tgt = vnom_q;
    endcase
  end
  wire slew_tick = (slew_cnt_q == SLEW_LAST);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_q <= 2'd1;
      ref_q <= 10'h000;
      slew_cnt_q <= 9'h000;
      fsup_q <= 1'b0;
    end else begin
      if (ramp_q[1]) begin
        bank_q <= 2'd0;
      end else if (io2_q < light_q) begin
        bank_q <= 2'd2;
      end else begin
        bank_q <= 2'd1;
      end
      // code 3 selects nominal, so only codes 1 and 2 are margins
      fsup_q <= oper_q[`ESC_OP_SUPPRESS] & (^oper_q[1:0]);
      slew_cnt_q <= slew_tick ? 9'h000 : slew_cnt_q + 9'h001;
      if (!running) begin
        ref_q <= tgt;
      end else if (slew_tick) begin
        // reference above sense: step down; below: step up
        if (sat_hi) begin
          if (ref_q != 10'h000) ref_q <= ref_q - 10'h001;
        end else if (sat_lo) begin
          if (ref_q != `ESC_REF_MAX) ref_q <= ref_q + 10'h001;
        end else if (ref_q < tgt) begin
          ref_q <= ref_q + 10'h001;
        end else if (ref_q > tgt) begin
          ref_q <= ref_q - 10'h001;
        end
      end
    end
  end

  // ******************************************************************
  // front end: sample, subtract, amplify, convert
  // ******************************************************************
  wire [4:0] cb = (bank_q == 2'd0) ? 5'd0 :
                  (bank_q == 2'd1) ? 5'd9 : 5'd18;
  wire [15:0] afe_word = coef_q[cb + `ESC_CI_AFE];
  wire [1:0] front_end_gain_code = afe_word[1:0];
  wire signed [13:0] err_w = $signed({4'b0000, ref_q}) -
                             $signed({diff_q[12], diff_q});
  // gain 1,2,4,8 then 8 mV full-step quantisation
  wire signed [16:0] scl_w = $signed({{3{err_w[13]}}, err_w}) <<< front_end_gain_code;
  wire signed [13:0] q_w = scl_w[16:3];
  reg [5:0] code_d;
  always @* begin
    if (q_w > 14'sd31) begin
      code_d = 6'h1F;
    end else if (q_w < -14'sd32) begin
      code_d = 6'h20;
    end else begin
      code_d = q_w[5:0];
    end
  end

  // ******************************************************************
  // compensator filter
  // ******************************************************************
  wire signed [15:0] nl_w;
  esc_nlgain u_nl (
    .err_code(code_q),
    .limits(nllim_q),
    .gains(nlg_q),
    .gained(nl_w)
  );
  wire signed [15:0] b0 = coef_q[cb + `ESC_CI_B0];
  wire signed [15:0] b1 = coef_q[cb + `ESC_CI_B1];
  wire signed [15:0] b2 = coef_q[cb + `ESC_CI_B2];
  wire signed [15:0] a1 = coef_q[cb + `ESC_CI_A1];
  wire signed [15:0] a2 = coef_q[cb + `ESC_CI_A2];
  wire signed [15:0] c0 = coef_q[cb + `ESC_CI_C0];
  wire signed [15:0] c1 = coef_q[cb + `ESC_CI_C1];
  wire signed [15:0] d1 = coef_q[cb + `ESC_CI_D1];
  wire signed [34:0] bq_sum = b0 * nl_w + b1 * x1_q + b2 * x2_q -
                              a1 * y1_q - a2 * y2_q;
  wire [15:0] y0_w = sat16(bq_sum >>> `ESC_QSHIFT);
  wire signed [34:0] fo_sum = c0 * $signed(y0_w) + c1 * y1_q -
                              d1 * z1_q;
  wire [15:0] z0_w = sat16(fo_sum >>> `ESC_QSHIFT);

  function [15:0] sat16;
    input [34:0] v;
    begin
      if (&v[34:15] || ~|v[34:15]) begin
        sat16 = v[15:0];
      end else begin
        sat16 = {v[34], {15{~v[34]}}};
      end
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= 16'h0000;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      diff_q <= 13'h0000;
      code_q <= 6'h00;
      x1_q <= 16'h0000;
      x2_q <= 16'h0000;
      y1_q <= 16'h0000;
      y2_q <= 16'h0000;
      z1_q <= 16'h0000;
      comp_q <= 16'h0000;
      comp_valid_q <= 1'b0;
    end else if (!running) begin
      pc_q <= 16'h0000;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      code_q <= 6'h00;
      x1_q <= 16'h0000;
      x2_q <= 16'h0000;
      y1_q <= 16'h0000;
      y2_q <= 16'h0000;
      z1_q <= 16'h0000;
      comp_valid_q <= 1'b0;
    end else begin
      pc_q <= (pc_q >= period_q - 16'h0001) ? 16'h0000 : pc_q + 16'h0001;
      s1_q <= (pc_q == stime_q);
      s2_q <= s1_q;
      comp_valid_q <= s2_q;
      if (s1_q) begin
        diff_q <= $signed({1'b0, sp2_q}) - $signed({1'b0, sn2_q});
      end
      if (s2_q) begin
        code_q <= code_d;
      end
      if (comp_valid_q) begin
        x1_q <= nl_w;
        x2_q <= x1_q;
        y1_q <= y0_w;
        y2_q <= y1_q;
        z1_q <= z0_w;
        comp_q <= z0_w;
      end
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign ref_dac = ref_q;
  assign comp_out = comp_q;
  assign comp_valid = comp_valid_q;
  assign fault_suppress = fsup_q;
endmodule
`default_nettype wire

// ==== sim/esc_sense_net.sv ====
// behavioural sense divider driving the differential sense inputs
`timescale 1ns/10ps
`default_nettype none
module esc_sense_net #(
  parameter int CM_MV = 200
) (
  input wire logic [11:0] vdiff_mv,
  output logic [11:0] sense_positive_input,
  output logic [11:0] sense_negative_input
);
  // a common-mode level on both legs must cancel in the difference
  assign sense_positive_input = vdiff_mv + 12'(CM_MV);
  assign sense_negative_input = 12'(CM_MV);
endmodule
`default_nettype wire

// ==== sim/esc_checker.sv ====
// port assertions for the error sense compensator
`timescale 1ns/10ps
`default_nettype none
module esc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic external_reset_n,
  input wire logic [9:0] ref_dac,
  input wire logic [15:0] comp_out,
  input wire logic comp_valid
);
  logic [12:0] up_q;
  logic [8:0] gap_q;
  logic [9:0] ref_q;
  logic run;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // cycles since reset pin high, reference step spacing
  // ****************************************
  assign run = up_q >= 13'h0faa;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_q <= 13'h0000;
      gap_q <= 9'h000;
      ref_q <= 10'h000;
    end else begin
      ref_q <= ref_dac;
      if (!external_reset_n)
        up_q <= 13'h0000;
      else if (up_q != 13'h1fff)
        up_q <= up_q + 13'h0001;
      if (ref_dac != ref_q)
        gap_q <= 9'h000;
      else if (gap_q != 9'h1ff)
        gap_q <= gap_q + 9'h001;
    end
  end
  write_no_wait_a: assert property (
    hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  read_one_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  rdata_hold_a: assert property (
    $changed(hrdata) |-> !$past(hreadyout) && hreadyout)
    else $error("read data moved outside a read");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  valid_pulse_a: assert property (
    comp_valid |=> !comp_valid)
    else $error("strobe too long");
  out_hold_a: assert property (
    $changed(comp_out) |-> $past(comp_valid))
    else $error("output moved without strobe");
  startup_wait_a: assert property (
    comp_valid |-> up_q == 13'h0000 || up_q >= 13'h0fa0)
    else $error("loop ran before startup delay");
  ext_hold_a: assert property (
    !external_reset_n [*5] |-> !comp_valid)
    else $error("loop ran in external reset");
  slew_step_a: assert property (
    run && ref_dac != ref_q |-> gap_q >= 9'h0ff &&
      (ref_dac - ref_q == 10'h001 || ref_q - ref_dac == 10'h001))
    else $error("reference step size or rate wrong");
endmodule
bind esc_top esc_checker chk_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .external_reset_n, .ref_dac,
  .comp_out, .comp_valid);
`default_nettype wire

// ==== sim/error_sense_compensator_tb.sv ====
// self-checking bench for the error sense compensator
`timescale 1ns/10ps
`default_nettype none
`include "esc_consts.vh"
module error_sense_compensator_tb;
  logic hclk, hresetn, hsel, hwrite, ext_n, ramp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  logic [11:0] vdiff, iout;
  wire logic [11:0] pos, neg;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, cv, fsup;
  wire logic [9:0] ref_dac;
  wire logic [15:0] comp_out;
  int n_errors, cmp_count, cyc;
  int ge[5] = '{0, 0, 1, 2, 3};
  int ee[5] = '{20, -12, -30, 15, -20};
  logic [5:0] ce[5] = '{6'h02, 6'h3e, 6'h38, 6'h07, 6'h2c};
  logic [5:0] cb[3] = '{6'h0a, 6'h01, 6'h02};
  int en[5] = '{-10, -6, 4, 6, 10};
  int gn[5] = '{16, 32, 48, 64, 80};
  int op[5] = '{5, 6, 4, 7, 1};
  int fs[5] = '{1, 1, 0, 0, 0};
  esc_sense_net net_i (.vdiff_mv(vdiff), .sense_positive_input(pos),
    .sense_negative_input(neg));
  esc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_reset_n(ext_n), .sense_positive_input(pos),
    .sense_negative_input(neg), .soft_ramp_active(ramp),
    .output_current(iout), .ref_dac(ref_dac), .comp_out(comp_out),
    .comp_valid(cv), .fault_suppress(fsup));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rdm(a, 32'hffff_ffff, e);
  endtask
  task automatic wv(input int n);
    repeat (n) begin
      @(posedge hclk);
      while (cv !== 1'b1) @(posedge hclk);
    end
    // let the output launched at the strobe edge settle
    @(posedge hclk);
  endtask
  task automatic wref(input logic [9:0] e);
    logic [9:0] r;
    r = ref_dac;
    @(posedge hclk);
    while (ref_dac === r) @(posedge hclk);
    chk({22'h0, ref_dac}, {22'h0, e});
  endtask
  function automatic logic [31:0] st(logic [5:0] c, logic [1:0] b);
    return {10'h000, c, 12'h000, b, 2'h1};
  endfunction
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ramp} = '0;
    ext_n = 1'b1;
    iout = 12'h200;
    vdiff = 12'h1f4;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`ESC_A_CTRL, 32'h1);
    rdc(`ESC_A_PERIOD, 32'h28);
    rdc(`ESC_A_STIME, 32'h14);
    rdc(`ESC_A_NLG03, 32'h1010_1010);
    rdc(`ESC_A_NLG4, 32'h10);
    rdc(12'h104, 32'h1000);
    rdc(12'h198, 32'h1000);
    rdc(12'h148, 32'h0);
    wr(12'h3f0, 32'hffff_ffff);
    rdc(12'h3f0, 32'h0);
    rdm(`ESC_A_STATUS, 32'h1, 32'h0);
    wr(`ESC_A_VNOM, 32'h1f4);
    wr(`ESC_A_LIGHT, 32'h0);
    rdc(`ESC_A_VNOM, 32'h1f4);
    $display("test registers done");
    repeat (4100) @(posedge hclk);
    rdm(`ESC_A_STATUS, 32'h1, 32'h1);
    chk({22'h0, ref_dac}, 32'h1f4);
    for (int i = 0; i < 5; i++) begin
      wr(12'h140, 32'(ge[i]));
      vdiff <= 12'(500 - ee[i]);
      wv(3);
      rdm(`ESC_A_STATUS, 32'h003f_000f, st(ce[i], 2'h1));
      chk({16'h0, comp_out}, {16'h0, 16'($signed(ce[i]) * 16)});
    end
    $display("test error codes done");
    wr(12'h100, 32'h3);
    wr(12'h180, 32'h1);
    wr(12'h140, 32'h0);
    wr(`ESC_A_LIGHT, 32'h100);
    vdiff <= 12'h1ea;
    for (int i = 0; i < 3; i++) begin
      ramp <= (i == 0);
      iout <= (i == 1) ? 12'h200 : 12'h050;
      wv(3);
      rdm(`ESC_A_STATUS, 32'h003f_000f, st(cb[i], 2'(i)));
    end
    ramp <= 1'b0;
    iout <= 12'h200;
    $display("test banks done");
    wr(12'h140, 32'h3);
    wr(`ESC_A_NLLIM, 32'h0020_4f38);
    wr(`ESC_A_NLG03, 32'h4030_2010);
    wr(`ESC_A_NLG4, 32'h50);
    for (int i = 0; i < 5; i++) begin
      vdiff <= 12'(500 - en[i]);
      wv(3);
      chk({16'h0, comp_out}, {16'h0, 16'(en[i] * gn[i])});
    end
    wr(12'h15c, 32'h1000);
    wv(3);
    chk({16'h0, comp_out}, 32'h0000_0640);
    $display("test nonlinear gain done");
    wr(`ESC_A_STIME, 32'h100);
    vdiff <= 12'h1f0;
    repeat (100) @(posedge hclk);
    rdm(`ESC_A_STATUS, 32'h003f_0000, 32'h000a_0000);
    wr(`ESC_A_STIME, 32'h14);
    wv(3);
    rdm(`ESC_A_STATUS, 32'h003f_0000, 32'h0004_0000);
    $display("test sample time done");
    vdiff <= 12'h21c;
    wref(10'h1f5);
    wref(10'h1f6);
    rdm(`ESC_A_STATUS, 32'h003f_0003, 32'h0020_0003);
    vdiff <= 12'h1ce;
    wref(10'h1f5);
    wref(10'h1f4);
    rdm(`ESC_A_STATUS, 32'h003f_0003, 32'h001f_0003);
    vdiff <= 12'h1f4;
    $display("test saturation done");
    wr(`ESC_A_VMHI, 32'h1fe);
    wr(`ESC_A_VMLO, 32'h1ea);
    for (int i = 0; i < 5; i++) begin
      wr(`ESC_A_OPER, 32'(op[i]));
      repeat (3) @(posedge hclk);
      chk({31'h0, fsup}, 32'(fs[i]));
    end
    for (int i = 0; i < 20 && ref_dac !== 10'h1fe; i++) begin
      wref(ref_dac + 10'h001);
    end
    chk({22'h0, ref_dac}, 32'h1fe);
    wr(`ESC_A_CTRL, 32'h0);
    rdm(`ESC_A_STATUS, 32'h1, 32'h0);
    wr(`ESC_A_CTRL, 32'h1);
    rdm(`ESC_A_STATUS, 32'h1, 32'h1);
    $display("test margin done");
    ext_n <= 1'b0;
    repeat (50) @(posedge hclk);
    rdm(`ESC_A_STATUS, 32'h1, 32'h0);
    rdc(`ESC_A_VNOM, 32'h1f4);
    ext_n <= 1'b1;
    repeat (4100) @(posedge hclk);
    rdm(`ESC_A_STATUS, 32'h1, 32'h1);
    wv(1);
    $display("test external reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
